// ===== rtl/fbp_pkg.sv
// Constants, field positions and types of the flash block protection logic.
// Assumes a 32-bit word flash array of 16 KB behind a single request port.
package fbp_pkg;

  // Array geometry
  localparam int FLASH_BYTES     = 16384;
  localparam int BLOCK_BYTES     = 1024;
  localparam int UNIT_BYTES      = 2048;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 14;
  localparam int WORD_ADDR_W     = 12;
  localparam int NUM_BLOCKS      = FLASH_BYTES / BLOCK_BYTES;
  localparam int NUM_UNITS       = FLASH_BYTES / UNIT_BYTES;
  localparam int NUM_WORDS       = FLASH_BYTES / (DATA_W / 8);
  localparam int WORDS_PER_BLOCK = BLOCK_BYTES / (DATA_W / 8);
  localparam int UNIT_W          = 3;
  localparam int BLOCK_W         = 4;
  localparam int ERASE_CNT_W     = 8;
  localparam int PROT_W          = 2;

  // Address field positions (byte address)
  localparam int WORD_LSB  = 2;
  localparam int BLOCK_LSB = 10;
  localparam int UNIT_LSB  = 11;

  // Values
  localparam logic [DATA_W-1:0]      ERASED_WORD    = 32'hFFFFFFFF;
  localparam logic [ERASE_CNT_W-1:0] ERASE_LAST_CNT = 8'hFF;
  localparam logic [ERASE_CNT_W-1:0] ERASE_CNT_RST  = 8'h00;
  localparam logic [DATA_W-1:0]      RDATA_RST      = 32'h00000000;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_ERASE   = 2'h2
  } fbp_op_type;

  typedef enum logic [1:0] {
    SRC_IFETCH = 2'h0,
    SRC_DATA   = 2'h1,
    SRC_DEBUG  = 2'h2
  } fbp_src_type;

  typedef enum logic [1:0] {
    PROT_OPEN      = 2'h0,
    PROT_READ_ONLY = 2'h1,
    PROT_EXEC_ONLY = 2'h2
  } fbp_prot_type;

  localparam logic [PROT_W-1:0] PROT_RST = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_ERASE = 3'b100
  } fbp_state_type;

endpackage

// ===== rtl/fbp_flash_array.sv
// Word-wide storage array of the flash, one port, registered read.
// Assumes the controller serialises all accesses onto the single port.
`timescale 1ns/1ns
module fbp_flash_array (
  // Clock
  input  wire logic                             clk,
  // Access port
  input  wire logic                             we,
  input  wire logic [fbp_pkg::WORD_ADDR_W-1:0]  addr,
  input  wire logic [fbp_pkg::DATA_W-1:0]       wdata,
  output logic      [fbp_pkg::DATA_W-1:0]       rdata
);
  import fbp_pkg::*;

  logic [DATA_W-1:0] mem [NUM_WORDS];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

endmodule

// ===== rtl/fbp_flash_protect.sv
// Flash controller with 1 KB block erase and 2 KB protection units.
// Assumes one requester at a time, arbitrated upstream, and a synchronous reset.
`timescale 1ns/1ns
// Operation
// (RULE_01) The 16 KB array is sixteen 1 KB blocks, each of which can be erased on its own.
// (RULE_02) A finished block erase leaves every bit of that block at one, so later reads return all ones.
// (RULE_03) Block pairs form eight 2 KB protection units, each with its own setting.
// (RULE_04) Each unit can be set open, read-only or execute-only.
// (RULE_05) A read-only unit refuses all erase and program requests.
// (RULE_06) An execute-only unit also refuses all erase and program requests.
// (RULE_07) An execute-only unit serves instruction fetches only and denies data and debugger reads.
// (RULE_08) One setting per unit is held in flops that the checker consults on every request.
module fbp_flash_protect (
  // Clock and reset
  input  wire logic                                   CLK,
  input  wire logic                                   RST,
  // Request
  input  wire logic                                   REQ_VALID,
  output logic                                        REQ_READY,
  input  wire fbp_pkg::fbp_op_type                    REQ_OP,
  input  wire fbp_pkg::fbp_src_type                   REQ_SRC,
  input  wire logic [fbp_pkg::ADDR_W-1:0]             REQ_ADDR,
  input  wire logic [fbp_pkg::DATA_W-1:0]             REQ_WDATA,
  // Response
  output logic                                        RSP_VALID,
  output logic                                        RSP_DENIED,
  output logic      [fbp_pkg::DATA_W-1:0]             RSP_RDATA,
  // Protection setting
  input  wire logic                                   PROT_WE,
  input  wire logic [fbp_pkg::UNIT_W-1:0]             PROT_UNIT,
  input  wire fbp_pkg::fbp_prot_type                  PROT_MODE,
  output logic      [fbp_pkg::NUM_UNITS*fbp_pkg::PROT_W-1:0] PROT_STATE
);
  import fbp_pkg::*;

  fbp_state_type            state_ff;
  fbp_state_type            nxt_state;
  logic [BLOCK_W-1:0]       erase_block_ff;
  logic [ERASE_CNT_W-1:0]   erase_cnt_ff;
  logic [PROT_W-1:0]        prot_mode [NUM_UNITS];
  logic [PROT_W-1:0]        req_mode;
  logic [UNIT_W-1:0]        req_unit;
  logic                     take;
  logic                     allowed;
  logic                     take_ok;
  logic                     take_deny;
  logic                     erase_go;
  logic                     prog_done;
  logic                     read_done;
  logic                     erase_end;
  logic                     arr_we;
  logic [WORD_ADDR_W-1:0]   arr_addr;
  logic [DATA_W-1:0]        arr_wdata;
  logic [DATA_W-1:0]        arr_rdata;

  // Protection table, one setting per 2 KB unit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++) begin : gen_unit
      logic [PROT_W-1:0] mode_ff;
      always_ff @(posedge CLK) begin
        if (RST) begin
          mode_ff <= PROT_RST;
        end else if (PROT_WE && (PROT_UNIT == UNIT_W'(gi))) begin
          mode_ff <= PROT_MODE; // [RULE_03] [RULE_04] [RULE_08]
        end
      end
      assign prot_mode[gi] = mode_ff;
      assign PROT_STATE[gi*PROT_W +: PROT_W] = mode_ff;
    end
  endgenerate

  // Access check against the unit that holds the address
  // Settings are flops, so a request is judged by the values that stood before its edge
  assign req_unit = REQ_ADDR[ADDR_W-1:UNIT_LSB]; // [RULE_03]
  assign req_mode = prot_mode[req_unit];         // [RULE_08]
  assign take     = REQ_VALID && REQ_READY;

  always_comb begin
    allowed = 1'b0;
    unique case (REQ_OP)
      OP_READ: begin
        if ((req_mode == PROT_OPEN) || (req_mode == PROT_READ_ONLY)) begin
          allowed = 1'b1;
        end else begin
          // Execute-only (and the unused code) admit only fetches
          allowed = (REQ_SRC == SRC_IFETCH); // [RULE_07]
        end
      end
      OP_PROGRAM, OP_ERASE: begin
        allowed = (req_mode == PROT_OPEN); // [RULE_05] [RULE_06]
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
  end

  // Sequencing
  // Refusals and programs finish in the taking edge, so only reads and erases leave idle
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take && allowed && (REQ_OP == OP_READ)) begin
          nxt_state = ST_READ;
        end else if (take && allowed && (REQ_OP == OP_ERASE)) begin
          nxt_state = ST_ERASE; // [RULE_01]
        end
      end
      ST_READ: begin
        nxt_state = ST_IDLE;
      end
      ST_ERASE: begin
        if (erase_cnt_ff == ERASE_LAST_CNT) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready follows the next state, so it is high exactly while the sequencer is idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      REQ_READY <= 1'b1;
    end else begin
      REQ_READY <= (nxt_state == ST_IDLE);
    end
  end

  // Request outcomes; a request is only taken in the idle state
  assign take_ok   = take && allowed;
  assign take_deny = take && !allowed;
  assign erase_go  = take_ok && (REQ_OP == OP_ERASE);
  assign prog_done = take_ok && (REQ_OP == OP_PROGRAM);
  assign read_done = (state_ff == ST_READ);
  assign erase_end = (state_ff == ST_ERASE) && (erase_cnt_ff == ERASE_LAST_CNT);

  // Block under erase, latched when the erase is admitted
  always_ff @(posedge CLK) begin
    if (RST) begin
      erase_block_ff <= '0;
    end else if (erase_go) begin
      erase_block_ff <= REQ_ADDR[ADDR_W-1:BLOCK_LSB]; // [RULE_01]
    end
  end

  // Word counter of the erase walk over the 256 words of one block
  always_ff @(posedge CLK) begin
    if (RST) begin
      erase_cnt_ff <= ERASE_CNT_RST;
    end else if (erase_go) begin
      erase_cnt_ff <= ERASE_CNT_RST;
    end else if (state_ff == ST_ERASE) begin
      erase_cnt_ff <= erase_cnt_ff + ERASE_CNT_W'(1);
    end
  end

  // Array port steering
  always_comb begin
    arr_we    = 1'b0;
    arr_addr  = REQ_ADDR[ADDR_W-1:WORD_LSB];
    arr_wdata = REQ_WDATA;
    if (state_ff == ST_ERASE) begin
      arr_we    = 1'b1;
      arr_addr  = {erase_block_ff, erase_cnt_ff};
      arr_wdata = ERASED_WORD; // [RULE_02]
    end else if ((state_ff == ST_IDLE) && take && allowed && (REQ_OP == OP_PROGRAM)) begin
      arr_we    = 1'b1; // [RULE_05] [RULE_06]
    end
  end

  fbp_flash_array u_array (
    .clk   (CLK),
    .we    (arr_we),
    .addr  (arr_addr),
    .wdata (arr_wdata),
    .rdata (arr_rdata)
  );

  // Response strobe: refusal, program, read data or last erase word
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
    end else begin
      RSP_VALID <= take_deny || prog_done || read_done || erase_end; // [RULE_02]
    end
  end

  // Refusal flag, raised only together with the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP_DENIED <= 1'b0;
    end else begin
      RSP_DENIED <= take_deny; // [RULE_05] [RULE_06] [RULE_07]
    end
  end

  // Read data, cleared on a refusal so that a denied read shows nothing of the array
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP_RDATA <= RDATA_RST;
    end else if (take_deny) begin
      RSP_RDATA <= RDATA_RST;
    end else if (read_done) begin
      RSP_RDATA <= arr_rdata; // [RULE_07]
    end
  end

endmodule

// ===== test/fbp_properties.sv
// Port checker of the flash protection controller.
// Assumes a bind onto fbp_flash_protect, one clock, synchronous reset.
`timescale 1ns/1ns
module fbp_properties (
  // Clock and reset
  input wire logic                       CLK,
  input wire logic                       RST,
  // Request
  input wire logic                       REQ_VALID,
  input wire logic                       REQ_READY,
  input wire fbp_pkg::fbp_op_type        REQ_OP,
  input wire fbp_pkg::fbp_src_type       REQ_SRC,
  input wire logic [13:0]                REQ_ADDR,
  // Response
  input wire logic                       RSP_VALID,
  input wire logic                       RSP_DENIED,
  input wire logic [31:0]                RSP_RDATA,
  // Protection setting
  input wire logic                       PROT_WE,
  input wire logic [2:0]                 PROT_UNIT,
  input wire fbp_pkg::fbp_prot_type      PROT_MODE,
  input wire logic [15:0]                PROT_STATE
);
  import fbp_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic       take;
  logic [1:0] m;
  logic [2:0] u_ff;
  logic [1:0] md_ff;
  assign take = REQ_VALID && REQ_READY;
  assign m = PROT_STATE[REQ_ADDR[13:11]*2 +: 2];
  always_ff @(posedge CLK) begin
    u_ff  <= PROT_UNIT;
    md_ff <= PROT_MODE;
  end
  sequence s_fetch_ans;
    !RSP_VALID ##1 (RSP_VALID && !RSP_DENIED);
  endsequence
  a_ro_deny: assert property (take && m == 2'h1 && REQ_OP != OP_READ |=> RSP_VALID && RSP_DENIED)
    else $error("read-only write admitted");
  a_xo_deny: assert property (take && m >= 2'h2 && REQ_OP != OP_READ |=> RSP_DENIED)
    else $error("exec-only write admitted");
  a_xo_data: assert property (take && m >= 2'h2 && REQ_OP == OP_READ && REQ_SRC != SRC_IFETCH
    |=> RSP_DENIED && RSP_RDATA == 32'h0) else $error("exec-only data read served");
  a_xo_fetch: assert property (take && m >= 2'h2 && REQ_OP == OP_READ && REQ_SRC == SRC_IFETCH
    |=> s_fetch_ans) else $error("exec-only fetch refused");
  a_erase_time: assert property (take && m == 2'h0 && REQ_OP == OP_ERASE
    |=> ##256 (RSP_VALID && !RSP_DENIED)) else $error("erase answer late");
  a_erase_busy: assert property (take && REQ_OP == OP_ERASE && m == 2'h0 |=> !REQ_READY [*8])
    else $error("ready during erase");
  a_prot_upd: assert property (PROT_WE && PROT_MODE <= PROT_EXEC_ONLY |=> PROT_STATE[u_ff*2 +: 2] == md_ff)
    else $error("setting not stored");
  a_open_prog: assert property (take && m == 2'h0 && REQ_OP == OP_PROGRAM |=> RSP_VALID && !RSP_DENIED)
    else $error("open program denied");
endmodule
bind fbp_flash_protect fbp_properties u_chk (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ_OP(REQ_OP), .REQ_SRC(REQ_SRC), .REQ_ADDR(REQ_ADDR), .RSP_VALID(RSP_VALID),
  .RSP_DENIED(RSP_DENIED), .RSP_RDATA(RSP_RDATA), .PROT_WE(PROT_WE), .PROT_UNIT(PROT_UNIT),
  .PROT_MODE(PROT_MODE), .PROT_STATE(PROT_STATE));

// ===== test/fbp_cpu_model.sv
// Requester model: fetch path, data path and debugger on one port.
// Assumes one outstanding request, driven just after rising edges.
`timescale 1ns/1ns
module fbp_cpu_model (
  // Clock
  input  wire logic                 clk,
  // Request
  output logic                      req_valid,
  input  wire logic                 req_ready,
  output fbp_pkg::fbp_op_type       req_op,
  output fbp_pkg::fbp_src_type      req_src,
  output logic [13:0]               req_addr,
  output logic [31:0]               req_wdata,
  // Response
  input  wire logic                 rsp_valid,
  input  wire logic                 rsp_denied,
  input  wire logic [31:0]          rsp_rdata
);
  import fbp_pkg::*;
  initial begin
    req_valid = 1'b0;
    req_op    = OP_READ;
    req_src   = SRC_IFETCH;
    req_addr  = 14'h0;
    req_wdata = 32'h0;
  end
  task automatic go(input fbp_op_type op, input fbp_src_type s, input logic [13:0] a,
                    input logic [31:0] d, output logic dn, output logic [31:0] rd);
    int n;
    req_valid <= 1'b1;
    req_op    <= op;
    req_src   <= s;
    req_addr  <= a;
    req_wdata <= d;
    do @(posedge clk); while (!req_ready);
    // Released lines show garbage, not the last value
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_wdata <= ~d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rsp_valid && n < 300);
    dn = rsp_valid ? rsp_denied : 1'bx;
    rd = rsp_rdata;
  endtask
endmodule

// ===== test/tb.sv
// Self-checking bench of the flash protection controller.
// Assumes the requester model and the bound port checker.
`timescale 1ns/1ns
module tb;
  import fbp_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         req_valid, req_ready, rsp_valid, rsp_denied, dn;
  fbp_op_type   req_op;
  fbp_src_type  req_src;
  logic [13:0]  req_addr;
  logic [31:0]  req_wdata, rsp_rdata, rd;
  logic         prot_we = 1'b0;
  logic [2:0]   prot_unit = 3'h0;
  fbp_prot_type prot_mode = PROT_OPEN;
  logic [15:0]  prot_state;
  int           mismatches = 0;
  int           cmp_count = 0;
  initial forever #20 clk = ~clk;
  fbp_flash_protect u_fbp_flash_protect (.CLK(clk), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_OP(req_op), .REQ_SRC(req_src), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
    .RSP_DENIED(rsp_denied), .RSP_RDATA(rsp_rdata), .PROT_WE(prot_we), .PROT_UNIT(prot_unit),
    .PROT_MODE(prot_mode), .PROT_STATE(prot_state));
  fbp_cpu_model u_cpu (.clk(clk), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_denied(rsp_denied), .rsp_rdata(rsp_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input fbp_op_type op, input fbp_src_type s, input logic [13:0] a, input logic [31:0] d);
    u_cpu.go(op, s, a, d, dn, rd);
    if (dn === 1'bx) begin
      mismatches++;
      $display("Error %0t: no response to the request", $time);
    end
  endtask
  task automatic prot(input logic [2:0] u, input fbp_prot_type m);
    prot_we   <= 1'b1;
    prot_unit <= u;
    prot_mode <= m;
    @(posedge clk);
    prot_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_erase;
    acc(OP_PROGRAM, SRC_DATA, 14'h0400, 32'h12345678);
    chk({31'h0, dn}, 32'h0);
    acc(OP_PROGRAM, SRC_DATA, 14'h07FC, 32'h0);
    acc(OP_PROGRAM, SRC_DATA, 14'h03FC, 32'hA5A5A5A5);
    acc(OP_ERASE, SRC_DEBUG, 14'h0400, 32'h0);
    acc(OP_READ, SRC_DATA, 14'h0400, 32'h0);
    chk(rd, 32'hFFFFFFFF);
    acc(OP_READ, SRC_DATA, 14'h07FC, 32'h0);
    chk(rd, 32'hFFFFFFFF);
    acc(OP_READ, SRC_DATA, 14'h03FC, 32'h0);
    chk(rd, 32'hA5A5A5A5);
    $display("test erase done");
  endtask
  task automatic t_ro;
    acc(OP_PROGRAM, SRC_DATA, 14'h0C00, 32'h0BADCAFE);
    prot(3'h1, PROT_READ_ONLY);
    chk({16'h0, prot_state}, 32'h4);
    acc(OP_PROGRAM, SRC_DATA, 14'h0C00, 32'h0);
    chk({31'h0, dn}, 32'h1);
    acc(OP_ERASE, SRC_DATA, 14'h0C00, 32'h0);
    chk({31'h0, dn}, 32'h1);
    acc(OP_READ, SRC_DEBUG, 14'h0C00, 32'h0);
    chk(rd, 32'h0BADCAFE);
    acc(OP_PROGRAM, SRC_DATA, 14'h1000, 32'h5);
    chk({31'h0, dn}, 32'h0);
    acc(fbp_op_type'(2'h3), SRC_DATA, 14'h0000, 32'h0);
    chk({31'h0, dn}, 32'h1);
    prot(3'h1, PROT_OPEN);
    $display("test read-only done");
  endtask
  task automatic t_xo;
    acc(OP_PROGRAM, SRC_DATA, 14'h1800, 32'hC0DE0001);
    for (int i = 2; i < 4; i++) begin
      prot(3'h3, fbp_prot_type'(i[1:0]));
      acc(OP_READ, SRC_IFETCH, 14'h1800, 32'h0);
      chk(rd, 32'hC0DE0001);
      acc(OP_READ, SRC_DATA, 14'h1800, 32'h0);
      chk({dn, rd[30:0]}, 32'h80000000);
      acc(OP_READ, SRC_DEBUG, 14'h1800, 32'h0);
      chk({31'h0, dn}, 32'h1);
      acc(OP_READ, fbp_src_type'(2'h3), 14'h1800, 32'h0);
      chk({31'h0, dn}, 32'h1);
      acc(OP_PROGRAM, SRC_IFETCH, 14'h1800, 32'h0);
      chk({31'h0, dn}, 32'h1);
      acc(OP_ERASE, SRC_DEBUG, 14'h1800, 32'h0);
      chk({31'h0, dn}, 32'h1);
    end
    prot(3'h3, PROT_OPEN);
    acc(OP_READ, SRC_DATA, 14'h1800, 32'h0);
    chk(rd, 32'hC0DE0001);
    $display("test exec-only done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({16'h0, prot_state}, 32'h0);
    t_erase;
    t_ro;
    t_xo;
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
